// >>> src/rtc_pkg.sv
// Shared constants and types for the calendar clock with alarms and outage detector.
package rtc_pkg;

  // Register offsets on the 6-bit register port.
  localparam logic [5:0] CAL_SEC = 6'h00;
  localparam logic [5:0] CAL_WDAY = 6'h06;
  localparam logic [5:0] ALM0_BASE = 6'h08;
  localparam logic [5:0] ALM_STRIDE = 6'h08;
  localparam logic [5:0] ALM_WMASK_OFS = 6'h06;
  localparam logic [5:0] ALM_CTRL_OFS = 6'h07;
  localparam logic [5:0] CORR_REG = 6'h18;
  localparam logic [5:0] OUTAGE_CTRL = 6'h19;
  localparam logic [5:0] STATUS_REG = 6'h1A;

  // Field positions inside registers.
  localparam int ALM_IGNORE_BIT = 7;
  localparam int ALM_ACT_BIT = 0;
  localparam int CORR_SLOW_BIT = 7;
  localparam int OUTAGE_EN_BIT = 7;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_OUT_RUN_BIT = 1;
  localparam int ST_OUT_FLAG_BIT = 2;
  localparam int ST_MATCH0_BIT = 3;
  localparam int NUM_FIELDS = 6;

  // Counting limits.
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [3:0] MONTH_MAX = 4'hC;
  localparam logic [6:0] YEAR_MAX = 7'h63;
  localparam logic [15:0] PRESC_MAX = 16'h7FFF;
  localparam int CORR_SHIFT = 5;
  localparam logic [9:0] CORR_PERIOD_SECS = 10'h202;
  localparam int OUTAGE_UNIT_SHIFT = 8;
  localparam logic [2:0] BASE_WEEKDAY = 3'h5;

  // Calendar write sequence time and its cycle count at the 125 MHz clock.
  localparam int UPDATE_TIME_US = 3000;
  localparam int CLK_MHZ = 125;
  localparam int UPDATE_CYCLES = UPDATE_TIME_US * CLK_MHZ;

  // Reset values: the whole clock domain starts at zero.
  localparam logic [7:0] CORR_RESET = 8'h00;
  localparam logic [7:0] OUTAGE_CTRL_RESET = 8'h00;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] sec;
  } cal_t;

  typedef struct packed {
    logic act;
    logic [NUM_FIELDS-1:0] ignore;
    logic [6:0] wmask;
    cal_t t;
  } alarm_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// >>> src/rtc_calendar.sv
// Calendar clock with two alarms, rate correction and brief outage detection.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module rtc_calendar #(
  parameter int unsigned UPDATE_CYCLES = rtc_pkg::UPDATE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire rtc_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic xtal_32k,
  input wire logic main_power_ok,
  input wire logic power_unit_working,
  output logic alarm_wake,
  output logic alarm_irq,
  output logic brief_outage_event
);
  import rtc_pkg::*;

  typedef struct packed {
    cal_t cal;
    alarm_t [1:0] alm;
    logic [7:0] corr;
    logic outage_en;
    logic [6:0] outage_len;
    logic [15:0] presc;
    logic [9:0] corr_secs;
    logic corr_now;
    logic [19:0] busy_cnt;
    logic [1:0] match_q;
    logic outage_run;
    logic [14:0] outage_cnt;
    logic outage_flag;
    logic x_q1;
    logic x_q2;
    logic x_prev;
    logic p_q1;
    logic p_q2;
    logic p_prev;
    logic [7:0] rdata;
    logic wake;
    logic irq;
    logic outage_evt;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // Month length, with the leap year rule for the 2000..2099 range.
  function automatic logic [4:0] month_days(input logic [3:0] m, input logic [6:0] y);
    case (m)
      4'h2: month_days = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'h1E;
      default: month_days = 5'h1F;
    endcase
  endfunction

  // Days before the first of a month in a common year.
  function automatic logic [8:0] days_before(input logic [3:0] m);
    case (m)
      4'h2: days_before = 9'h01F;
      4'h3: days_before = 9'h03B;
      4'h4: days_before = 9'h05A;
      4'h5: days_before = 9'h078;
      4'h6: days_before = 9'h097;
      4'h7: days_before = 9'h0B5;
      4'h8: days_before = 9'h0D4;
      4'h9: days_before = 9'h0F3;
      4'hA: days_before = 9'h111;
      4'hB: days_before = 9'h130;
      4'hC: days_before = 9'h14E;
      default: days_before = 9'h000;
    endcase
  endfunction

  // Weekday follows from the date itself, so any date write keeps it right.
  function automatic logic [6:0] weekday(input cal_t c);
    logic [16:0] days;
    logic [2:0] idx;
    days = 17'(c.year) * 17'h0016D + 17'((c.year + 7'h03) >> 2) + 17'(days_before(c.month));
    if (c.year[1:0] == 2'h0 && c.month > 4'h2) begin
      days = days + 17'h00001;
    end
    days = days + 17'(c.day) - 17'h00001 + 17'(BASE_WEEKDAY);
    idx = 3'(days % 17'h00007);
    weekday = 7'h01 << idx;
  endfunction

  // One second step with carries through every unit.
  function automatic cal_t advance(input cal_t c);
    cal_t r;
    r = c;
    if (c.sec >= SEC_MAX) begin
      r.sec = 6'h00;
      if (c.minute >= SEC_MAX) begin
        r.minute = 6'h00;
        if (c.hour >= HOUR_MAX) begin
          r.hour = 5'h00;
          if (c.day >= month_days(c.month, c.year)) begin
            r.day = 5'h01;
            if (c.month >= MONTH_MAX) begin
              r.month = 4'h1;
              r.year = (c.year >= YEAR_MAX) ? 7'h00 : c.year + 7'h01;
            end else begin
              r.month = c.month + 4'h1;
            end
          end else begin
            r.day = c.day + 5'h01;
          end
        end else begin
          r.hour = c.hour + 5'h01;
        end
      end else begin
        r.minute = c.minute + 6'h01;
      end
    end else begin
      r.sec = c.sec + 6'h01;
    end
    advance = r;
  endfunction

  // Field f of a calendar value, zero extended to seven bits.
  function automatic logic [6:0] get_field(input cal_t c, input int f);
    case (f)
      0: get_field = {1'b0, c.sec};
      1: get_field = {1'b0, c.minute};
      2: get_field = {2'b00, c.hour};
      3: get_field = {2'b00, c.day};
      4: get_field = {3'b000, c.month};
      default: get_field = c.year;
    endcase
  endfunction

  function automatic cal_t set_field(input cal_t c, input int f, input logic [7:0] d);
    cal_t r;
    r = c;
    case (f)
      0: r.sec = d[5:0];
      1: r.minute = d[5:0];
      2: r.hour = d[4:0];
      3: r.day = d[4:0];
      4: r.month = d[3:0];
      default: r.year = d[6:0];
    endcase
    set_field = r;
  endfunction

  // An alarm matches when active, every non-excluded unit agrees and its wmask holds the weekday.
  function automatic logic alarm_match(input alarm_t a, input cal_t c, input logic [6:0] wd);
    logic m;
    m = a.act;
    for (int f = 0; f < NUM_FIELDS; f++) begin
      if (!a.ignore[f] && get_field(a.t, f) != get_field(c, f)) begin
        m = 1'b0;
      end
    end
    if ((a.wmask & wd) == 7'h00) begin
      m = 1'b0;
    end
    alarm_match = m;
  endfunction

  logic [6:0] wday;
  logic xtal_tick;
  logic sec_tick;
  logic [15:0] presc_end;
  logic [15:0] corr_amount;
  logic [5:0] alm_base;
  logic [1:0] match_now;

  // All next-state logic of the block.
  always_comb begin
    s_nxt = s_r;
    wday = weekday(s_r.cal);
    sec_tick = 1'b0;
    alm_base = 6'h00;
    match_now = 2'b00;
    s_nxt.wake = 1'b0;
    s_nxt.irq = 1'b0;
    s_nxt.outage_evt = 1'b0;

    // Two-stage synchronisers for the crystal and supply pins.
    s_nxt.x_q1 = xtal_32k;
    s_nxt.x_q2 = s_r.x_q1;
    s_nxt.x_prev = s_r.x_q2;
    s_nxt.p_q1 = main_power_ok;
    s_nxt.p_q2 = s_r.p_q1;
    s_nxt.p_prev = s_r.p_q2;
    xtal_tick = s_r.x_q2 & ~s_r.x_prev;

    // During a correction second the prescaler end moves by code * 32 periods.
    corr_amount = {4'h0, s_r.corr[6:0], 5'h00};
    if (!s_r.corr_now) begin
      presc_end = PRESC_MAX;
    end else if (s_r.corr[CORR_SLOW_BIT]) begin
      presc_end = PRESC_MAX + corr_amount;
    end else begin
      presc_end = PRESC_MAX - corr_amount;
    end
    if (xtal_tick) begin
      if (s_r.presc >= presc_end) begin
        s_nxt.presc = 16'h0000;
        sec_tick = 1'b1;
      end else begin
        s_nxt.presc = s_r.presc + 16'h0001;
      end
    end

    // Counting never stops, whatever the power unit is doing.
    if (sec_tick) begin
      s_nxt.cal = advance(s_r.cal);
      s_nxt.corr_now = 1'b0;
      if (s_r.corr_secs >= CORR_PERIOD_SECS - 10'h001) begin
        s_nxt.corr_secs = 10'h000;
        s_nxt.corr_now = 1'b1;
      end else begin
        s_nxt.corr_secs = s_r.corr_secs + 10'h001;
      end
    end

    if (s_r.busy_cnt != 20'h00000) begin
      s_nxt.busy_cnt = s_r.busy_cnt - 20'h00001;
    end

    // Outage timer: runs on crystal periods while main power is away.
    if (s_r.outage_run) begin
      if (s_r.p_q2) begin
        s_nxt.outage_run = 1'b0;
        s_nxt.outage_en = 1'b0;
        s_nxt.outage_evt = 1'b1;
      end else if (xtal_tick) begin
        if (s_r.outage_cnt >= 15'({s_r.outage_len, 8'h00})) begin
          s_nxt.outage_run = 1'b0;
          s_nxt.outage_en = 1'b0;
        end else begin
          s_nxt.outage_cnt = s_r.outage_cnt + 15'h0001;
        end
      end
    end else if (s_r.outage_en && s_r.p_prev && !s_r.p_q2) begin
      s_nxt.outage_run = 1'b1;
      s_nxt.outage_cnt = 15'h0000;
    end

    // Each alarm raises its request only on the rising edge of its match.
    for (int i = 0; i < 2; i++) begin
      match_now[i] = alarm_match(s_r.alm[i], s_r.cal, wday);
      if (match_now[i] && !s_r.match_q[i]) begin
        if (power_unit_working) begin
          s_nxt.irq = 1'b1;
        end else begin
          s_nxt.wake = 1'b1;
        end
      end
    end
    s_nxt.match_q = match_now;

    // Register writes win over the count for the field they touch.
    if (reg_req.wr) begin
      for (int f = 0; f < NUM_FIELDS; f++) begin
        if (reg_req.addr == CAL_SEC + 6'(f)) begin
          s_nxt.cal = set_field(s_nxt.cal, f, reg_req.wdata);
          s_nxt.busy_cnt = 20'(UPDATE_CYCLES);
          if (f == 0) begin
            s_nxt.presc = 16'h0000;
          end
        end
      end
      for (int i = 0; i < 2; i++) begin
        alm_base = ALM0_BASE + 6'(i) * ALM_STRIDE;
        for (int f = 0; f < NUM_FIELDS; f++) begin
          if (reg_req.addr == alm_base + 6'(f)) begin
            s_nxt.alm[i].t = set_field(s_r.alm[i].t, f, reg_req.wdata);
            s_nxt.alm[i].ignore[f] = reg_req.wdata[ALM_IGNORE_BIT];
          end
        end
        if (reg_req.addr == alm_base + ALM_WMASK_OFS) begin
          s_nxt.alm[i].wmask = reg_req.wdata[6:0];
        end
        if (reg_req.addr == alm_base + ALM_CTRL_OFS) begin
          s_nxt.alm[i].act = reg_req.wdata[ALM_ACT_BIT];
        end
      end
      if (reg_req.addr == CORR_REG) begin
        s_nxt.corr = reg_req.wdata;
      end
      if (reg_req.addr == OUTAGE_CTRL) begin
        s_nxt.outage_en = reg_req.wdata[OUTAGE_EN_BIT];
        s_nxt.outage_len = reg_req.wdata[6:0];
      end
      if (reg_req.addr == STATUS_REG && reg_req.wdata[ST_OUT_FLAG_BIT]) begin
        s_nxt.outage_flag = 1'b0;
      end
    end
    // Setting after the clear means an event in the clearing cycle survives.
    if (s_nxt.outage_evt) begin
      s_nxt.outage_flag = 1'b1;
    end

    // Read data is registered and stands in the cycle after the strobe.
    s_nxt.rdata = 8'h00;
    if (reg_req.rd) begin
      for (int f = 0; f < NUM_FIELDS; f++) begin
        if (reg_req.addr == CAL_SEC + 6'(f)) begin
          s_nxt.rdata = {1'b0, get_field(s_r.cal, f)};
        end
      end
      if (reg_req.addr == CAL_WDAY) begin
        s_nxt.rdata = {1'b0, wday};
      end
      for (int i = 0; i < 2; i++) begin
        alm_base = ALM0_BASE + 6'(i) * ALM_STRIDE;
        for (int f = 0; f < NUM_FIELDS; f++) begin
          if (reg_req.addr == alm_base + 6'(f)) begin
            s_nxt.rdata = {s_r.alm[i].ignore[f], get_field(s_r.alm[i].t, f)};
          end
        end
        if (reg_req.addr == alm_base + ALM_WMASK_OFS) begin
          s_nxt.rdata = {1'b0, s_r.alm[i].wmask};
        end
        if (reg_req.addr == alm_base + ALM_CTRL_OFS) begin
          s_nxt.rdata = {7'h00, s_r.alm[i].act};
        end
      end
      if (reg_req.addr == CORR_REG) begin
        s_nxt.rdata = s_r.corr;
      end
      if (reg_req.addr == OUTAGE_CTRL) begin
        s_nxt.rdata = {s_r.outage_en, s_r.outage_len};
      end
      if (reg_req.addr == STATUS_REG) begin
        s_nxt.rdata[ST_BUSY_BIT] = (s_r.busy_cnt != 20'h00000);
        s_nxt.rdata[ST_OUT_RUN_BIT] = s_r.outage_run;
        s_nxt.rdata[ST_OUT_FLAG_BIT] = s_r.outage_flag;
        s_nxt.rdata[ST_MATCH0_BIT +: 2] = s_r.match_q;
      end
    end
  end

  // Reset stands for power-up of the clock domain: everything goes to zero.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.corr <= CORR_RESET;
      s_r.outage_en <= OUTAGE_CTRL_RESET[OUTAGE_EN_BIT];
      s_r.outage_len <= OUTAGE_CTRL_RESET[6:0];
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign alarm_wake = s_r.wake;
  assign alarm_irq = s_r.irq;
  assign brief_outage_event = s_r.outage_evt;

endmodule // rtc_calendar

// >>> tb/rtc_calendar_properties.sv
// Concurrent checks on the ports of the calendar clock block.
`timescale 1ns/1ps
module rtc_calendar_properties
  import rtc_pkg::*;
#(
  parameter int unsigned UPDATE_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire rtc_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic xtal_32k,
  input wire logic main_power_ok,
  input wire logic power_unit_working,
  input wire logic alarm_wake,
  input wire logic alarm_irq,
  input wire logic brief_outage_event
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Read data only shows in the cycle after a read strobe.
  property p_rdata_idle;
    !$past(reg_req.rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read answer");

  property p_wday_onehot;
    $past(reg_req.rd) && $past(reg_req.addr) == CAL_WDAY |-> $onehot(reg_rdata);
  endproperty
  a_wday_onehot: assert property (p_wday_onehot)
    else $error("weekday read is not one-hot");

  property p_sec_range;
    $past(reg_req.rd) && $past(reg_req.addr) == CAL_SEC |-> reg_rdata <= 8'h3B;
  endproperty
  a_sec_range: assert property (p_sec_range)
    else $error("seconds read above 59");

  // The mode input decides which of the two alarm outputs may pulse.
  property p_irq_mode;
    alarm_irq |-> $past(power_unit_working) && !alarm_wake;
  endproperty
  a_irq_mode: assert property (p_irq_mode)
    else $error("alarm interrupt outside working mode");

  property p_wake_mode;
    alarm_wake |-> !$past(power_unit_working);
  endproperty
  a_wake_mode: assert property (p_wake_mode)
    else $error("alarm wake outside standby");

  property p_alarm_pulse;
    (alarm_irq || alarm_wake) |=> !alarm_irq && !alarm_wake;
  endproperty
  a_alarm_pulse: assert property (p_alarm_pulse)
    else $error("alarm request longer than one cycle");

  // An outage event needs power back now and missing a few cycles earlier.
  property p_outage_src;
    brief_outage_event |-> main_power_ok && !$past(main_power_ok, 8);
  endproperty
  a_outage_src: assert property (p_outage_src)
    else $error("outage event without a recent power return");

  property p_outage_pulse;
    brief_outage_event |=> !brief_outage_event;
  endproperty
  a_outage_pulse: assert property (p_outage_pulse)
    else $error("outage event longer than one cycle");

  property p_alarm_rw;
    (reg_req.wr && reg_req.addr == ALM0_BASE && !reg_req.wdata[6]) ##2
      (reg_req.rd && reg_req.addr == ALM0_BASE) |=> reg_rdata == $past(reg_req.wdata, 3);
  endproperty
  a_alarm_rw: assert property (p_alarm_rw)
    else $error("alarm seconds read back differs from write");

  // Busy is only checked in the first few cycles, well inside the update window.
  property p_busy;
    (reg_req.wr && reg_req.addr <= 6'h05) ##2 (reg_req.rd && reg_req.addr == STATUS_REG)
      |=> reg_rdata[ST_BUSY_BIT];
  endproperty
  a_busy: assert property (p_busy)
    else $error("update busy missing after calendar write");

  c_irq: cover property (alarm_irq);
  c_wake: cover property (alarm_wake);
  c_outage: cover property (brief_outage_event);
endmodule // rtc_calendar_properties

bind rtc_calendar rtc_calendar_properties #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .xtal_32k(xtal_32k), .main_power_ok(main_power_ok), .power_unit_working(power_unit_working),
  .alarm_wake(alarm_wake), .alarm_irq(alarm_irq), .brief_outage_event(brief_outage_event));

// >>> tb/rtc_far_side_model.sv
// Far-side model: crystal oscillator and main supply monitor feeding the calendar block.
`timescale 1ns/1ps
module rtc_far_side_model #(
  parameter int XTAL_HALF_NS = 16
) (
  input wire logic power_cut,
  output logic xtal_32k,
  output logic main_power_ok
);
  // The crystal runs far faster than 32.768 kHz so that outage expiry fits a short run.
  // Prescaler and outage counts are in crystal periods, so their expectations scale with XTAL_HALF_NS.
  initial begin
    xtal_32k = 1'b0;
    #3;
    forever #(XTAL_HALF_NS) xtal_32k = ~xtal_32k;
  end

  // Supply is present unless the bench cuts it.
  assign main_power_ok = ~power_cut;
endmodule // rtc_far_side_model

// >>> tb/test_rtc_calendar.sv
// Self-checking bench for the calendar clock: registers, alarms and outage detection.
`timescale 1ns/1ps
module test_rtc_calendar;
  import rtc_pkg::*;
  localparam int UPD = 20;
  logic ref_clk;
  logic reset_n;
  reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic xtal_32k;
  logic main_power_ok;
  logic power_unit_working;
  logic alarm_wake;
  logic alarm_irq;
  logic brief_outage_event;
  logic power_cut;
  int num_errors = 0;
  int n_tests = 0;
  int irq_cnt = 0;
  int wake_cnt = 0;
  int out_cnt = 0;
  int cycles = 0;
  int t_sec = 0;
  // Year, month, day and the weekday expected for that date.
  logic [7:0] dates [6][4] = '{'{8'h00, 8'h01, 8'h01, 8'h20}, '{8'h00, 8'h01, 8'h03, 8'h01},
    '{8'h00, 8'h02, 8'h1D, 8'h02}, '{8'h00, 8'h03, 8'h01, 8'h04},
    '{8'h01, 8'h01, 8'h01, 8'h01}, '{8'h01, 8'h03, 8'h01, 8'h08}};
  // Alarm 1: time 10:21:59 with the date excluded, Thursday only, activated.
  logic [7:0] al1 [8] = '{8'h3B, 8'h15, 8'h0A, 8'h80, 8'h80, 8'h80, 8'h08, 8'h01};

  rtc_calendar #(.UPDATE_CYCLES(UPD)) u_rtc_calendar (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .xtal_32k(xtal_32k),
    .main_power_ok(main_power_ok), .power_unit_working(power_unit_working),
    .alarm_wake(alarm_wake), .alarm_irq(alarm_irq), .brief_outage_event(brief_outage_event));

  // A crystal period of two clock cycles lets one whole second pass within the run.
  rtc_far_side_model #(.XTAL_HALF_NS(8)) u_rtc_far_side_model (.power_cut(power_cut),
    .xtal_32k(xtal_32k),
    .main_power_ok(main_power_ok));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Pulse counters, plus a cycle ceiling so a hang still ends in a verdict.
  always @(posedge ref_clk) begin
    cycles++;
    if (alarm_irq === 1'b1) irq_cnt++;
    if (alarm_wake === 1'b1) wake_cnt++;
    if (brief_outage_event === 1'b1) out_cnt++;
    if (cycles == 80000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report;
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] expected, input string what);
    n_tests++;
    if (seen !== expected) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, expected);
    end
  endtask

  // Each access is one strobe cycle followed by one idle cycle.
  task automatic reg_write(input logic [5:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    reg_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask

  task automatic expect_reg(input logic [5:0] addr, input logic [7:0] expected);
    @(posedge ref_clk);
    reg_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
    check(reg_rdata, expected, $sformatf("register %h", addr));
  endtask

  task automatic alm_write(input logic k, input logic [5:0] ofs, input logic [7:0] data);
    reg_write(ALM0_BASE + (k ? ALM_STRIDE : 6'h00) + ofs, data);
  endtask

  task automatic outage(input int n);
    @(posedge ref_clk);
    power_cut <= 1'b1;
    repeat (n) @(posedge ref_clk);
    power_cut <= 1'b0;
    repeat (20) @(posedge ref_clk);
  endtask

  initial begin
    reset_n = 1'b0;
    reg_req = '0;
    power_cut = 1'b0;
    power_unit_working = 1'b1;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 27; a++) begin
      if (a != 6) expect_reg(a[5:0], 8'h00);
    end
    // Calendar reads wait out the update window after every calendar write.
    for (int i = 0; i < 6; i++) begin
      reg_write(CAL_SEC + 6'h05, dates[i][0]);
      reg_write(CAL_SEC + 6'h04, dates[i][1]);
      reg_write(CAL_SEC + 6'h03, dates[i][2]);
      reg_write(CAL_WDAY, 8'h7F);
      repeat (UPD + 4) @(posedge ref_clk);
      expect_reg(CAL_WDAY, dates[i][3]);
    end
    expect_reg(CAL_SEC + 6'h04, 8'h03);
    reg_write(CAL_SEC + 6'h02, 8'h0A);
    reg_write(CAL_SEC + 6'h01, 8'h14);
    reg_write(CAL_SEC, 8'h3B);
    t_sec = cycles;
    expect_reg(STATUS_REG, 8'h01);
    repeat (UPD + 4) @(posedge ref_clk);
    expect_reg(STATUS_REG, 8'h00);
    expect_reg(CAL_SEC, 8'h3B);
    // Alarm 0 with every unit excluded fires once, then again only on re-entry.
    reg_write(ALM0_BASE, 8'hBB);
    expect_reg(ALM0_BASE, 8'hBB);
    for (int f = 1; f < 6; f++) alm_write(1'b0, f[5:0], 8'h80);
    alm_write(1'b0, ALM_WMASK_OFS, 8'h7F);
    alm_write(1'b0, ALM_CTRL_OFS, 8'h01);
    repeat (50) @(posedge ref_clk);
    check(irq_cnt[7:0], 8'h01, "irq once");
    alm_write(1'b0, ALM_WMASK_OFS, 8'h77);
    repeat (10) @(posedge ref_clk);
    check(irq_cnt[7:0], 8'h01, "irq day masked");
    alm_write(1'b0, ALM_WMASK_OFS, 8'h08);
    repeat (10) @(posedge ref_clk);
    check(irq_cnt[7:0], 8'h02, "irq re-entry");
    alm_write(1'b0, ALM_WMASK_OFS, 8'h00);
    alm_write(1'b0, ALM_CTRL_OFS, 8'h00);
    alm_write(1'b0, ALM_WMASK_OFS, 8'h7F);
    repeat (10) @(posedge ref_clk);
    check(irq_cnt[7:0], 8'h02, "irq inactive");
    // Alarm 1 in standby: a wrong minute blocks it, the right minute wakes the unit.
    @(posedge ref_clk);
    power_unit_working <= 1'b0;
    for (int f = 0; f < 8; f++) alm_write(1'b1, f[5:0], al1[f]);
    repeat (20) @(posedge ref_clk);
    check(wake_cnt[7:0], 8'h00, "wake mismatch");
    alm_write(1'b1, 6'h01, 8'h14);
    repeat (20) @(posedge ref_clk);
    check(wake_cnt[7:0], 8'h01, "wake");
    check(irq_cnt[7:0], 8'h02, "irq in standby");
    // Outage length 1 unit is 257 crystal edges, about 514 cycles here.
    reg_write(OUTAGE_CTRL, 8'h81);
    outage(200);
    check(out_cnt[7:0], 8'h01, "short outage");
    expect_reg(STATUS_REG, 8'h14);
    reg_write(STATUS_REG, 8'h04);
    expect_reg(STATUS_REG, 8'h10);
    outage(200);
    check(out_cnt[7:0], 8'h01, "outage not enabled");
    reg_write(OUTAGE_CTRL, 8'h81);
    outage(600);
    check(out_cnt[7:0], 8'h01, "long outage");
    reg_write(OUTAGE_CTRL, 8'h81);
    outage(480);
    check(out_cnt[7:0], 8'h02, "outage under limit");
    // One second is 32768 crystal periods, counted from the write of the seconds field.
    while (cycles < t_sec + 65520) @(posedge ref_clk);
    expect_reg(CAL_SEC, 8'h3B);
    repeat (30) @(posedge ref_clk);
    expect_reg(CAL_SEC, 8'h00);
    expect_reg(CAL_SEC + 6'h01, 8'h15);
    final_report();
  end
endmodule // test_rtc_calendar
